// File: logic/efd_ctrl.sv
// ecp fifo, dma request and interrupt control
//
// Function
// - forward byte with host ack high is data, low is a command
// - command bit 7 selects run-length count or channel address
// - reverse byte with peripheral ack low is command; channels unsupported
// - received run-length count n repeats the next data byte n plus one
// - control line drivers open-collector in mode 000, push-pull otherwise
// - service disable bit blocks dma requests and service interrupts
// - clearing service disable with condition holding interrupts at once
// - interrupt is a short low pulse then released for sharing
// - terminal count with dma interrupts and sets service disable
// - pio forward interrupts while free bytes reach write level
// - pio reverse interrupts while stored bytes reach read level
// - fault falling edge or error enable falling with fault interrupts
// - ack rising edge interrupts when ack interrupt enabled
// - threshold field plus one is effective; sixteen acts as fifteen
// - fifo disabled after reset; usable only in fifo or ecp mode
// - dma request limited to 32 transfers, then rest 350 ns after ack
// - reverse dma requests while fifo holds data; drops on empty or tc
// - last byte request drops on ack active or on read strobe
// - request returns with one byte; after tc also needs service enable
// - data fifo at 400h, address fifo at 000h forward only
// - service levels are sixteen minus effective threshold
// - mode 010 is fifo mode, 011 ecp mode, fifo reset in 000
`timescale 1ns/10ps

module efd_ctrl
    import efd_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset,
    // avalon-mm slave
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // isa dma and interrupt
    output logic             o_port_dma_request,
    input  wire logic        i_port_dma_ack_n,
    input  wire logic        i_tc,
    input  wire logic        i_ior_n,
    output logic             o_port_irq_out,
    output logic             o_port_irq_oe,
    // forward link towards peripheral
    output efd_byte_s        o_fwd_byte,
    output logic             o_fwd_valid,
    input  wire logic        i_fwd_ready,
    // reverse link from peripheral
    input  efd_byte_s        i_rev_byte,
    input  wire logic        i_rev_valid,
    output logic             o_rev_ready,
    // peripheral status pins and driver style
    input  wire logic        i_fault_n,
    input  wire logic        i_ack_n,
    output logic             o_ctl_open_collector
);

    // ====================
    // state
    // ====================
    logic [11:0] ctl, next_ctl;
    efd_byte_s   mem [FIFO_DEPTH];
    logic [3:0]  wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [4:0]  count, next_count;
    logic [7:0]  rle, next_rle;
    logic        rle_pend, next_rle_pend;
    logic [7:0]  rdata, next_rdata;
    logic        ack_q, next_ack_q;
    efd_drq_e    drq_st, next_drq_st;
    logic [5:0]  burst, next_burst;
    logic [4:0]  idle, next_idle;
    logic        ack_n_q, next_ack_n_q, fault_n_q, next_fault_n_q, ior_n_q, next_ior_n_q;
    logic        cond_q, next_cond_q;
    logic [2:0]  pulse, next_pulse;
    logic        fwd_v, next_fwd_v;
    efd_byte_s   fwd_b, next_fwd_b;

    // ====================
    // decode
    // ====================
    logic [2:0] mode;
    logic       dir, svc_dis, dma_en, err_en_n, ack_en;
    logic [4:0] thr_eff, level, free_cnt;
    logic       fifo_on, bus_wr, bus_rd, dack, dma_xfer;
    logic       push, pop, push_host, pop_host, push_rev, pop_fwd;
    efd_byte_s  push_b;
    logic       svc_cond, irq_event;

    assign mode     = ctl[CTL_MODE_LSB +: 3];
    assign dir      = ctl[CTL_DIR];
    assign svc_dis  = ctl[CTL_SVC_DIS];
    assign dma_en   = ctl[CTL_DMA_EN];
    assign err_en_n = ctl[CTL_ERR_EN_N];
    assign ack_en   = ctl[CTL_ACK_EN];
    assign thr_eff  = (ctl[CTL_THR_LSB +: 4] == 4'hf) ? THR_CAP : {1'b0, ctl[CTL_THR_LSB +: 4]} + 5'h01;
    assign level    = FIFO_DEPTH_W - thr_eff;
    assign free_cnt = FIFO_DEPTH_W - count;
    // fifo usable only in fifo or ecp mode
    assign fifo_on  = (mode == MODE_PFIFO) || (mode == MODE_ECP);

    assign o_avs_waitrequest = 1'b0;
    assign bus_wr = i_avs_write;
    assign bus_rd = i_avs_read;
    assign dack   = ~i_port_dma_ack_n;
    assign dma_xfer = dack && !ack_q;

    // data port and address port pushes, address forward only
    // software supplies counts through the address port
    always_comb begin
        push_host = 1'b0;
        push_b    = '{is_cmd: 1'b0, data: i_avs_writedata[7:0]};
        if (fifo_on && !dir && bus_wr && i_avs_address == REG_DATA_FIFO) begin
            push_host = 1'b1;
        end else if (fifo_on && !dir && mode == MODE_ECP && bus_wr
                     && i_avs_address == REG_ADDRESS_FIFO) begin
            push_host = 1'b1;
            push_b.is_cmd = 1'b1;
        end else if (fifo_on && !dir && dma_en && dma_xfer) begin
            push_host = 1'b1;
            push_b.data = 8'h00;
        end
    end

    // reverse commands taken in only as counts; channel addresses dropped
    // each copy is stored while the data byte is held on the link
    assign push_rev    = fifo_on && dir && count != FIFO_DEPTH_W
                         && i_rev_valid && !i_rev_byte.is_cmd;
    assign o_rev_ready = fifo_on && dir && count != FIFO_DEPTH_W
                         && !(push_rev && rle_pend && |rle);
    assign pop_host = fifo_on && dir && count != 5'h00
                      && ((bus_rd && i_avs_address == REG_RX_FIFO) || (dma_en && dma_xfer));
    // forward qualifier rides along with each byte
    assign pop_fwd  = fifo_on && !dir && count != 5'h00 && (!fwd_v || i_fwd_ready);
    assign push = (push_host && count != FIFO_DEPTH_W) || push_rev;
    assign pop  = pop_host || pop_fwd;

    // ====================
    // fifo, rle and register file next state
    // ====================
    always_comb begin
        next_ctl = ctl;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        next_rle = rle;
        next_rle_pend = rle_pend;
        next_rdata = rdata;
        next_fwd_v = fwd_v;
        next_fwd_b = fwd_b;
        next_ack_q = dack;
        if (bus_wr && i_avs_address == REG_CONTROL) begin
            next_ctl = i_avs_writedata[11:0];
        end
        if (!svc_dis && dma_en && i_tc && dack) begin
            next_ctl[CTL_SVC_DIS] = 1'b1;
        end
        // bit 7 low marks a run-length count
        if (push_rev && rle_pend && rle != 8'h00) begin
            next_rle = rle - 8'h01;
        end
        if (o_rev_ready && i_rev_valid && i_rev_byte.is_cmd && !i_rev_byte.data[CMD_TYPE_BIT]) begin
            next_rle = {1'b0, i_rev_byte.data[6:0]};
            next_rle_pend = 1'b1;
        end else if (push_rev && rle == 8'h00) begin
            next_rle_pend = 1'b0;
        end
        if (push) begin
            next_wr_ptr = wr_ptr + 4'h1;
        end
        if (pop) begin
            next_rd_ptr = rd_ptr + 4'h1;
        end
        next_count = count + {4'h0, push} - {4'h0, pop};
        if (pop_host) begin
            next_rdata = mem[rd_ptr].data;
        end
        if (pop_fwd) begin
            next_fwd_v = 1'b1;
            next_fwd_b = mem[rd_ptr];
        end else if (i_fwd_ready) begin
            next_fwd_v = 1'b0;
        end
        // fifo held reset outside its modes
        if (!fifo_on) begin
            next_wr_ptr = 4'h0;
            next_rd_ptr = 4'h0;
            next_count = 5'h00;
            next_rle_pend = 1'b0;
            next_fwd_v = 1'b0;
        end
    end

    always_comb begin
        o_avs_readdata = 32'h0;
        case (i_avs_address)
            REG_CONTROL:  o_avs_readdata = {20'h0, ctl};
            REG_STATUS:   o_avs_readdata = {23'h0, o_port_dma_request, count,
                                            count == FIFO_DEPTH_W, count == 5'h00};
            REG_CONFIG_A: o_avs_readdata = {24'h0, 8'h10};
            REG_RX_FIFO:  o_avs_readdata = {24'h0, rdata};
            default:      o_avs_readdata = 32'h0;
        endcase
    end

    // ====================
    // dma request machine
    // ====================
    always_comb begin
        next_drq_st = drq_st;
        next_burst = burst;
        next_idle = idle;
        next_ior_n_q = i_ior_n;
        case (drq_st)
            EFD_DRQ_IDLE: begin
                next_burst = 6'h00;
                if (fifo_on && dma_en && !svc_dis
                    && ((dir && count != 5'h00) || (!dir && count != FIFO_DEPTH_W))) begin
                    next_drq_st = EFD_DRQ_ACTIVE;
                end
            end
            EFD_DRQ_ACTIVE: begin
                if (dma_xfer) begin
                    next_burst = burst + 6'h01;
                end
                // drop on terminal count or empty
                // last byte drops on ack or read strobe edge
                if (svc_dis || !dma_en || (i_tc && dack)) begin
                    next_drq_st = EFD_DRQ_TC;
                end else if ((dir && (count == 5'h00 || (count == 5'h01 && (dma_xfer
                              || (ior_n_q && !i_ior_n)))))
                             || (!dir && count == FIFO_DEPTH_W)) begin
                    next_drq_st = EFD_DRQ_IDLE;
                end else if (dma_xfer && burst == DMA_BURST_MAX - 6'h01) begin
                    next_drq_st = EFD_DRQ_REST;
                    next_idle = 5'h00;
                end
            end
            EFD_DRQ_REST: begin
                if (dack) begin
                    next_idle = 5'h00;
                end else if (idle == ACK_IDLE_CNT - 5'h01) begin
                    next_drq_st = EFD_DRQ_IDLE;
                end else begin
                    next_idle = idle + 5'h01;
                end
            end
            EFD_DRQ_TC: begin
                // after tc wait for service enable
                if (svc_dis == 1'b0 || !dma_en) begin
                    next_drq_st = EFD_DRQ_IDLE;
                end
            end
            default: next_drq_st = EFD_DRQ_IDLE;
        endcase
    end

    assign o_port_dma_request = (drq_st == EFD_DRQ_ACTIVE) && !svc_dis;

    // ====================
    // interrupts
    // ====================
    // write level, read level
    assign svc_cond = fifo_on && !dma_en
                      && ((!dir && free_cnt >= level) || (dir && count >= level));

    always_comb begin
        next_ack_n_q = i_ack_n;
        next_fault_n_q = i_fault_n;
        next_cond_q = svc_cond && !svc_dis;
        irq_event = 1'b0;
        // condition rising, including service enable release
        if (svc_cond && !svc_dis && !cond_q) begin
            irq_event = 1'b1;
        end
        if (!svc_dis && dma_en && i_tc && dack) begin
            irq_event = 1'b1;
        end
        // fault edge or error enable falling
        if (!err_en_n && fault_n_q && !i_fault_n) begin
            irq_event = 1'b1;
        end
        if (bus_wr && i_avs_address == REG_CONTROL && err_en_n
            && !i_avs_writedata[CTL_ERR_EN_N] && !i_fault_n) begin
            irq_event = 1'b1;
        end
        if (ack_en && !ack_n_q && i_ack_n) begin
            irq_event = 1'b1;
        end
        next_pulse = (pulse != 3'h0) ? pulse - 3'h1 : 3'h0;
        if (irq_event) begin
            next_pulse = IRQ_PULSE_CNT;
        end
    end

    // drive low only during the pulse, released otherwise
    assign o_port_irq_out = 1'b0;
    assign o_port_irq_oe  = (pulse != 3'h0);
    assign o_ctl_open_collector = (mode == MODE_SPP);
    assign o_fwd_valid = fwd_v;
    assign o_fwd_byte  = fwd_b;

    // ====================
    // registers
    // ====================
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            ctl <= CTL_RESET;
            wr_ptr <= 4'h0;
            rd_ptr <= 4'h0;
            count <= 5'h00;
            rle <= 8'h00;
            rle_pend <= 1'b0;
            rdata <= 8'h00;
            ack_q <= 1'b0;
            drq_st <= EFD_DRQ_IDLE;
            burst <= 6'h00;
            idle <= 5'h00;
            ack_n_q <= 1'b1;
            fault_n_q <= 1'b1;
            ior_n_q <= 1'b1;
            cond_q <= 1'b0;
            pulse <= 3'h0;
            fwd_v <= 1'b0;
            fwd_b <= '0;
        end else begin
            ctl <= next_ctl;
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            rle <= next_rle;
            rle_pend <= next_rle_pend;
            rdata <= next_rdata;
            ack_q <= next_ack_q;
            drq_st <= next_drq_st;
            burst <= next_burst;
            idle <= next_idle;
            ack_n_q <= next_ack_n_q;
            fault_n_q <= next_fault_n_q;
            ior_n_q <= next_ior_n_q;
            cond_q <= next_cond_q;
            pulse <= next_pulse;
            fwd_v <= next_fwd_v;
            fwd_b <= next_fwd_b;
        end
    end

    // storage array, written only on push
    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= push_host ? push_b : '{is_cmd: 1'b0, data: i_rev_byte.data};
        end
    end

endmodule : efd_ctrl

// File: logic/efd_pkg.sv
// package for the ecp fifo, dma and interrupt control block
package efd_pkg;

    // ====================
    // register map (avalon word addresses are byte offset / 4)
    // ====================
    localparam logic [3:0] REG_DATA_FIFO    = 4'h0;
    localparam logic [3:0] REG_ADDRESS_FIFO = 4'h1;
    localparam logic [3:0] REG_CONTROL      = 4'h2;
    localparam logic [3:0] REG_STATUS       = 4'h3;
    localparam logic [3:0] REG_CONFIG_A     = 4'h4;
    localparam logic [3:0] REG_RX_FIFO      = 4'h5;

    // printed port offsets, kept for software reference
    localparam logic [11:0] PORT_DATA_FIFO    = 12'h400;
    localparam logic [11:0] PORT_ADDRESS_FIFO = 12'h000;

    // ====================
    // control register fields
    // ====================
    localparam int CTL_MODE_LSB   = 0;
    localparam int CTL_DIR        = 3;
    localparam int CTL_SVC_DIS    = 4;
    localparam int CTL_DMA_EN     = 5;
    localparam int CTL_ERR_EN_N   = 6;
    localparam int CTL_ACK_EN     = 7;
    localparam int CTL_THR_LSB    = 8;
    localparam logic [11:0] CTL_RESET = 12'h054;

    // ====================
    // modes and command encoding
    // ====================
    localparam logic [2:0] MODE_SPP  = 3'h0;
    localparam logic [2:0] MODE_PFIFO = 3'h2;
    localparam logic [2:0] MODE_ECP  = 3'h3;
    localparam int CMD_TYPE_BIT = 7;

    // ====================
    // fifo and timing
    // ====================
    localparam int FIFO_DEPTH = 16;
    localparam logic [4:0] FIFO_DEPTH_W = 5'h10;
    localparam logic [4:0] THR_CAP = 5'h0f;
    localparam logic [5:0] DMA_BURST_MAX = 6'h20;
    localparam int CLK_PERIOD_NS = 20;
    localparam int ACK_IDLE_NS = 350;
    localparam int ACK_IDLE_CYC = (ACK_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] ACK_IDLE_CNT = 5'(ACK_IDLE_CYC);
    localparam int IRQ_PULSE_NS = 100;
    localparam logic [2:0] IRQ_PULSE_CNT = 3'(IRQ_PULSE_NS / CLK_PERIOD_NS);

    // link byte with its command qualifier
    typedef struct packed {
        logic       is_cmd;
        logic [7:0] data;
    } efd_byte_s;

    typedef enum logic [1:0] {
        EFD_DRQ_IDLE,
        EFD_DRQ_ACTIVE,
        EFD_DRQ_REST,
        EFD_DRQ_TC
    } efd_drq_e;

endpackage : efd_pkg

// File: verif/efd_ctrl_properties.sv
// assertion checker for the ecp fifo, dma and interrupt control block
`timescale 1ns/10ps

module efd_ctrl_props
    import efd_pkg::*;
(
    // clock and reset
    input wire logic        i_clk_sys,
    input wire logic        i_reset,
    // register bus
    input wire logic [3:0]  i_avs_address,
    input wire logic        i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic        o_avs_waitrequest,
    // dma, interrupt and status pins
    input wire logic        o_port_dma_request,
    input wire logic        i_port_dma_ack_n,
    input wire logic        i_tc,
    input wire logic        o_port_irq_out,
    input wire logic        o_port_irq_oe,
    input wire logic        i_fault_n,
    input wire logic        i_ack_n,
    input wire logic        o_ctl_open_collector
);
    // ====================
    // shadow of control writes and dma bookkeeping
    logic [11:0] ctl, next_ctl;
    logic [4:0]  idle, next_idle;
    logic [5:0]  burst, next_burst;
    logic        tc_hold, next_tc_hold;
    logic        dack_d, next_dack_d;
    logic        ctl_wr;

    assign ctl_wr = i_avs_write && !o_avs_waitrequest && (i_avs_address == REG_CONTROL);

    always_comb begin
        next_ctl    = ctl_wr ? i_avs_writedata[11:0] : ctl;
        next_dack_d = i_port_dma_ack_n;
        next_idle   = !i_port_dma_ack_n ? 5'h00 : idle + {4'h0, idle != 5'h1f};
        next_burst  = (dack_d && !i_port_dma_ack_n) ? burst + 6'h01
                    : (idle >= ACK_IDLE_CNT) ? 6'h00 : burst;
        // only a fresh control write may release a terminal count stop
        next_tc_hold = (i_tc && !i_port_dma_ack_n) || (tc_hold && !ctl_wr);
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            ctl     <= CTL_RESET;
            idle    <= 5'h00;
            burst   <= 6'h00;
            tc_hold <= 1'b0;
            dack_d  <= 1'b1;
        end else begin
            ctl     <= next_ctl;
            idle    <= next_idle;
            burst   <= next_burst;
            tc_hold <= next_tc_hold;
            dack_d  <= next_dack_d;
        end
    end

    // ====================
    // properties
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    a_irq_line_low: assert property (o_port_irq_out == 1'b0)
        else $error("irq line driven high");
    a_irq_pulse_len: assert property ($rose(o_port_irq_oe) |-> o_port_irq_oe[*5] ##1 !o_port_irq_oe)
        else $error("irq pulse length wrong");
    a_oc_by_mode: assert property ($stable(ctl) |-> o_ctl_open_collector == (ctl[2:0] == MODE_SPP))
        else $error("driver style does not follow mode");
    a_svc_blocks_drq: assert property ($stable(ctl) && ctl[CTL_SVC_DIS] |-> !o_port_dma_request)
        else $error("dma request while service disabled");
    a_ack_edge_irq: assert property (ctl[CTL_ACK_EN] && $rose(i_ack_n) |-> ##[1:3] o_port_irq_oe)
        else $error("no irq on ack rise");
    a_fault_irq: assert property (!ctl[CTL_ERR_EN_N] && $fell(i_fault_n) |-> ##[1:3] o_port_irq_oe)
        else $error("no irq on fault fall");
    a_tc_raises_irq: assert property (i_tc && !i_port_dma_ack_n && ctl[CTL_DMA_EN] && !ctl[CTL_SVC_DIS]
        && !tc_hold |-> ##[1:3] o_port_irq_oe)
        else $error("no irq on terminal count");
    a_tc_stops_drq: assert property (tc_hold |-> !o_port_dma_request)
        else $error("dma request after terminal count");
    a_burst_rest: assert property (burst == 6'h20 && $past(burst) == 6'h20 && idle < 5'd17
        |-> !o_port_dma_request)
        else $error("dma request before rest ended");

    c_irq: cover property ($rose(o_port_irq_oe));
    c_burst: cover property (burst == 6'h20);
    c_tc: cover property (tc_hold);
endmodule : efd_ctrl_props

bind efd_ctrl efd_ctrl_props efd_ctrl_props_i (.*);

// File: verif/efd_link_peer.sv
// far-side ecp peripheral model on the link ports
`timescale 1ns/10ps

module efd_link_peer
    import efd_pkg::*;
(
    // clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_reset,
    // links
    output logic      o_fwd_ready,
    output efd_byte_s o_rev_byte,
    output logic      o_rev_valid,
    input  wire logic i_rev_ready,
    // pacing from the bench
    input  wire logic i_stall
);
    efd_byte_s rev_q[$];

    // forward bytes of either kind taken, slowed by stalls
    assign o_fwd_ready = !i_stall;

    task automatic send(input logic cmd, input logic [7:0] d);
        rev_q.push_back({cmd, d});
    endtask : send

    // qualifier travels with the byte; released lines show the inverse
    always @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_rev_valid <= 1'b0;
            o_rev_byte  <= '0;
        end else if (o_rev_valid && i_rev_ready) begin
            o_rev_valid <= 1'b0;
            o_rev_byte  <= ~o_rev_byte;
        end else if (!o_rev_valid && rev_q.size() > 0) begin
            o_rev_byte  <= rev_q.pop_front();
            o_rev_valid <= 1'b1;
        end
    end
endmodule : efd_link_peer

// File: verif/tb.sv
// self-checking bench for the ecp fifo, dma and interrupt control block
`timescale 1ns/10ps

module tb;
    import efd_pkg::*;

    // ====================
    // signals
    logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, ack_n = 1'b1, tc = 1'b0;
    logic        ior_n = 1'b1, fault_n = 1'b1, pin_ack_n = 1'b1, stall = 1'b0, oe_d = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, q, seed = 32'ha94c;
    logic        wreq, drq, irq, irq_oe, fwd_v, fwd_rdy, rev_v, rev_rdy, oc;
    efd_byte_s   fwd_b, rev_b, fb;
    efd_byte_s   exp_q[$];
    logic [7:0]  rx_q[$];
    logic [8:0]  rle [6] = '{9'h100, 9'h011, 9'h102, 9'h03c, 9'h181, 9'h05a};
    int          errors = 0, total_checks = 0, irq_cnt = 0, n0;

    efd_ctrl efd_ctrl_i (.i_clk_sys(clk), .i_reset(rst), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wreq), .o_port_dma_request(drq), .i_port_dma_ack_n(ack_n),
        .i_tc(tc), .i_ior_n(ior_n), .o_port_irq_out(irq), .o_port_irq_oe(irq_oe),
        .o_fwd_byte(fwd_b), .o_fwd_valid(fwd_v), .i_fwd_ready(fwd_rdy), .i_rev_byte(rev_b),
        .i_rev_valid(rev_v), .o_rev_ready(rev_rdy), .i_fault_n(fault_n), .i_ack_n(pin_ack_n),
        .o_ctl_open_collector(oc));
    efd_link_peer efd_link_peer_i (.i_clk_sys(clk), .i_reset(rst), .o_fwd_ready(fwd_rdy),
        .o_rev_byte(rev_b), .o_rev_valid(rev_v), .i_rev_ready(rev_rdy), .i_stall(stall));

    initial begin
        forever #10 clk = ~clk;
    end

    // ====================
    // helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        if (n >= 50) check("waitrequest", wreq, 32'h0);
    endtask : bus

    // leave through mode 000 so every mode change is a legal one
    task automatic go(input logic [11:0] c);
        // mode 000 clears the fifo, so queued bytes leave first
        for (int n = 0; n < 300 && exp_q.size() > 0; n++) @(posedge clk);
        bus(1'b1, REG_CONTROL, 32'h050);
        bus(1'b1, REG_CONTROL, {20'h0, c});
    endtask : go

    task automatic dma(input logic t);
        int n;
        n = 0;
        while (drq !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        ack_n <= 1'b0;
        ior_n <= 1'b0;
        tc <= t;
        @(posedge clk);
        ack_n <= 1'b1;
        ior_n <= 1'b1;
        tc <= 1'b0;
        @(posedge clk);
    endtask : dma

    task automatic final_report();
        if (errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report

    // ====================
    // output watcher, irq counter and far-side pacing
    always @(posedge clk) begin
        oe_d <= irq_oe;
        stall <= (xs() & 32'h3) == 32'h0;
        if (irq_oe === 1'b1 && oe_d === 1'b0) irq_cnt++;
        if (fwd_v === 1'b1 && fwd_rdy) begin
            if (exp_q.size() == 0) check("fwd_extra", fwd_b, 32'hffff_ffff);
            else check("fwd_byte", fwd_b, exp_q.pop_front());
        end
    end

    initial begin
        #400000;
        errors++;
        final_report();
    end

    // ====================
    // scenarios
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, REG_CONTROL, 32'h0);
        check("ctl_reset", q[11:0], CTL_RESET);
        bus(1'b1, REG_DATA_FIFO, 32'h99);
        bus(1'b0, REG_STATUS, 32'h0);
        check("fifo_off", q[0], 32'h1);
        // compressed and random forward traffic, then mode 010
        go(12'h053);
        for (int i = 0; i < 9; i++) begin
            n0 = xs();
            fb = (i == 0) ? 9'h105 : (i == 1) ? 9'h0a5 : (i == 2) ? 9'h185 : {1'b0, n0[7:0]};
            exp_q.push_back(fb);
            bus(1'b1, fb.is_cmd ? REG_ADDRESS_FIFO : REG_DATA_FIFO, {24'h0, fb.data});
        end
        go(12'h052);
        bus(1'b1, REG_ADDRESS_FIFO, 32'h77);
        exp_q.push_back(9'h03e);
        bus(1'b1, REG_DATA_FIFO, 32'h3e);
        go(12'h053);
        n0 = irq_cnt;
        bus(1'b1, REG_CONTROL, 32'h043);
        tick(12);
        check("pio_fwd_irq", irq_cnt - n0, 32'h1);
        // thresholds 13..15 with one stored byte
        for (int t = 13; t < 16; t++) begin
            go({t[3:0], 8'h5b});
            efd_link_peer_i.send(1'b0, 8'h6c);
            tick(10);
            n0 = irq_cnt;
            bus(1'b1, REG_CONTROL, {20'h0, t[3:0], 8'h4b});
            tick(12);
            check("pio_rev_irq", irq_cnt - n0, {31'h0, t > 13});
        end
        // reverse run-length expansion and a dropped channel address
        go(12'h05b);
        rx_q = '{8'h11, 8'h3c, 8'h3c, 8'h3c, 8'h5a};
        for (int i = 0; i < 6; i++) efd_link_peer_i.send(rle[i][8], rle[i][7:0]);
        tick(40);
        bus(1'b0, REG_STATUS, 32'h0);
        check("rx_count", q[6:2], 32'h5);
        bus(1'b0, REG_RX_FIFO, 32'h0);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, REG_RX_FIFO, 32'h0);
            check("rx_byte", q[7:0], rx_q.pop_front());
        end
        // ack and fault pin interrupts
        n0 = irq_cnt;
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, REG_CONTROL, (i == 0) ? 32'h0d0 : 32'h050);
            pin_ack_n <= 1'b0;
            tick(3);
            pin_ack_n <= 1'b1;
            tick(10);
        end
        fault_n <= 1'b0;
        tick(10);
        bus(1'b1, REG_CONTROL, 32'h010);
        tick(10);
        fault_n <= 1'b1;
        tick(10);
        fault_n <= 1'b0;
        tick(10);
        check("pin_irq", irq_cnt - n0, 32'h3);
        // reverse dma: gating, empty drop, refill, terminal count
        go(12'h07b);
        for (int i = 0; i < 3; i++) efd_link_peer_i.send(1'b0, 8'h20 + i[7:0]);
        tick(20);
        check("drq_svc", drq, 32'h0);
        bus(1'b1, REG_CONTROL, 32'h06b);
        tick(3);
        check("drq_data", drq, 32'h1);
        repeat (3) dma(1'b0);
        check("drq_empty", drq, 32'h0);
        efd_link_peer_i.send(1'b0, 8'h44);
        tick(10);
        check("drq_refill", drq, 32'h1);
        n0 = irq_cnt;
        dma(1'b1);
        efd_link_peer_i.send(1'b0, 8'h45);
        tick(10);
        check("drq_tc", drq, 32'h0);
        check("tc_irq", irq_cnt - n0, 32'h1);
        bus(1'b0, REG_CONTROL, 32'h0);
        check("svc_set", q[CTL_SVC_DIS], 32'h1);
        bus(1'b1, REG_CONTROL, 32'h06b);
        tick(3);
        check("drq_resume", drq, 32'h1);
        // forward dma burst limit and rest
        go(12'h063);
        for (int i = 0; i < 32; i++) begin
            exp_q.push_back(9'h000);
            dma(1'b0);
        end
        check("drq_burst", drq, 32'h0);
        tick(14);
        check("drq_rest", drq, 32'h0);
        tick(8);
        check("drq_again", drq, 32'h1);
        bus(1'b1, REG_CONTROL, 32'h053);
        for (int n = 0; n < 500 && exp_q.size() > 0; n++) @(posedge clk);
        check("fwd_left", exp_q.size(), 32'h0);
        final_report();
    end
endmodule : tb
